// File: core/fele_line_coder.sv
// Purpose: 100 Mb/s line coding path: 4B/5B, scrambler, NRZI, MLT3.
// Assumes: One coded bit per core clock; MAC holds each nibble until take.
// Notes:   Fiber mode sends NRZI only and parks the three-level output.
// How it works
// - NRZI output toggles on every one bit.
// - NRZI output holds on every zero bit.
// - TX mode gives exactly three line levels.
// - Three-level coder steps once per NRZI change in TX mode.
// - From low, step to middle then high.
// - From high, step to middle then low.
// - TX mode scrambles coded bits before NRZI.
// - Frame starts with eight preamble/SFD octets.
// - Six-octet destination address follows the preamble.
// - Six-octet source address follows the destination.
// - Payload must be 46 to 1500 octets.
// - Four-octet check field ends the data.
// - End delimiter octet, then idles between frames.
// - Data nibbles map to fixed five-bit groups.
// - Control symbols use their reserved code groups.
// - Invalid groups are never sent, flagged on receive; code 5'h19 is not flagged.
`timescale 1ns/100ps
module fele_line_coder
    import fele_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_b,
    // Mode: high for twisted pair, low for fiber.
    input  wire logic       i_mode_tx,
    // Transmit nibbles from the MAC.
    input  wire logic       i_tx_en,
    input  wire logic       i_tx_er,
    input  wire logic [3:0] i_txd,
    output logic            o_tx_take,
    output logic      [2:0] o_tx_field,
    output logic            o_tx_frame_err,
    // Line side transmit.
    output logic            o_tx_nrzi,
    output logic      [1:0] o_tx_mlt3,
    // Receive code groups and decoded output.
    input  wire logic [4:0] i_rx_code,
    input  wire logic       i_rx_code_vld,
    output logic      [3:0] o_rx_nibble,
    output logic            o_rx_data_vld,
    output logic      [2:0] o_rx_ctrl,
    output logic            o_rx_sym_err
);

    typedef enum logic [1:0] {TX_IDLE, TX_SSD2, TX_DATA, TX_ESD2}
        fele_tx_state_type;
    typedef enum logic [1:0] {ML_LOW, ML_MID_UP, ML_HIGH, ML_MID_DN}
        fele_mlt_state_type;

    fele_tx_state_type  tx_state_ff;
    fele_tx_state_type  nxt_tx_state;
    fele_mlt_state_type mlt_state_ff;
    fele_mlt_state_type nxt_mlt_state;
    logic [4:0]  shift_ff;
    logic [4:0]  nxt_shift;
    logic [2:0]  bit_cnt_ff;
    logic [2:0]  nxt_bit_cnt;
    logic [11:0] nib_cnt_ff;
    logic [11:0] nxt_nib_cnt;
    logic        frame_err_ff;
    logic        nxt_frame_err;
    logic [10:0] scr_ff;
    logic [10:0] nxt_scr;
    logic        nrzi_ff;
    logic        nxt_nrzi;
    logic [1:0]  mlt3_ff;
    logic [1:0]  nxt_mlt3;
    logic [2:0]  field_ff;
    logic [2:0]  nxt_field;
    logic        load;
    logic        scr_key;
    logic        line_bit;
    logic [11:0] nib_inc;

    // Framing and serialiser.
    always_comb
    begin
        load          = (bit_cnt_ff == FELE_BIT_LAST);
        nib_inc       = (nib_cnt_ff == FELE_NIB_SAT) ? nib_cnt_ff
                                                     : nib_cnt_ff + 12'h001;
        nxt_tx_state  = tx_state_ff;
        nxt_nib_cnt   = nib_cnt_ff;
        nxt_frame_err = 1'b0;
        nxt_bit_cnt   = load ? 3'h0 : bit_cnt_ff + 3'h1;
        nxt_shift     = {shift_ff[3:0], 1'b0};
        o_tx_take     = 1'b0;
        if (load)
        begin
            unique case (tx_state_ff)
                TX_IDLE:
                begin
                    if (i_tx_en)
                    begin
                        // First two preamble nibbles are replaced by the start pair.
                        nxt_shift    = FELE_CG_SSD1;
                        nxt_tx_state = TX_SSD2;
                        nxt_nib_cnt  = 12'h001;
                        o_tx_take    = 1'b1;
                    end
                    else
                    begin
                        nxt_shift = FELE_CG_IDLE;
                    end
                end
                TX_SSD2:
                begin
                    nxt_shift    = FELE_CG_SSD2;
                    nxt_tx_state = TX_DATA;
                    nxt_nib_cnt  = nib_inc;
                    o_tx_take    = 1'b1;
                end
                TX_DATA:
                begin
                    if (i_tx_en)
                    begin
                        nxt_shift   = i_tx_er ? FELE_CG_TXERR
                                              : fele_enc4b5b(i_txd);
                        nxt_nib_cnt = nib_inc;
                        o_tx_take   = 1'b1;
                    end
                    else
                    begin
                        // Whole octets, fixed fields plus check plus payload.
                        nxt_frame_err = nib_cnt_ff[0] ||
                                        (nib_cnt_ff < FELE_NIB_MIN) ||
                                        (nib_cnt_ff > FELE_NIB_MAX);
                        nxt_shift     = FELE_CG_ESD1;
                        nxt_tx_state  = TX_ESD2;
                    end
                end
                TX_ESD2:
                begin
                    nxt_shift    = FELE_CG_ESD2;
                    nxt_tx_state = TX_IDLE;
                    nxt_nib_cnt  = 12'h000;
                end
            endcase
        end
    end

    // Field tracking of the group now on the line.
    always_comb
    begin
        nxt_field = field_ff;
        if (load)
        begin
            if (nxt_tx_state == TX_IDLE && tx_state_ff == TX_IDLE)
            begin
                nxt_field = FELE_FLD_IDLE;
            end
            else if (nxt_tx_state == TX_ESD2 || tx_state_ff == TX_ESD2)
            begin
                nxt_field = FELE_FLD_END;
            end
            else if (nxt_nib_cnt <= FELE_NIB_PRE_END)
            begin
                nxt_field = FELE_FLD_PRE;
            end
            else if (nxt_nib_cnt <= FELE_NIB_DA_END)
            begin
                nxt_field = FELE_FLD_DA;
            end
            else if (nxt_nib_cnt <= FELE_NIB_SA_END)
            begin
                nxt_field = FELE_FLD_SA;
            end
            else if (nxt_nib_cnt <= FELE_NIB_LEN_END)
            begin
                nxt_field = FELE_FLD_LEN;
            end
            else
            begin
                nxt_field = FELE_FLD_DATA;
            end
        end
    end

    // Scrambler, NRZI and three-level coder.
    always_comb
    begin
        scr_key  = scr_ff[10] ^ scr_ff[8];
        nxt_scr  = {scr_ff[9:0], scr_key};
        line_bit = shift_ff[4] ^ (i_mode_tx & scr_key);
        nxt_nrzi = nrzi_ff ^ line_bit;
        nxt_mlt_state = mlt_state_ff;
        if (line_bit && i_mode_tx)
        begin
            unique case (mlt_state_ff)
                ML_LOW:    nxt_mlt_state = ML_MID_UP;
                ML_MID_UP: nxt_mlt_state = ML_HIGH;
                ML_HIGH:   nxt_mlt_state = ML_MID_DN;
                ML_MID_DN: nxt_mlt_state = ML_LOW;
            endcase
        end
        unique case (nxt_mlt_state)
            ML_LOW:    nxt_mlt3 = FELE_LVL_LOW;
            ML_HIGH:   nxt_mlt3 = FELE_LVL_HIGH;
            ML_MID_UP: nxt_mlt3 = FELE_LVL_MID;
            ML_MID_DN: nxt_mlt3 = FELE_LVL_MID;
        endcase
        if (!i_mode_tx)
        begin
            nxt_mlt3 = FELE_LVL_MID;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_state_ff  <= TX_IDLE;
            mlt_state_ff <= ML_LOW;
            shift_ff     <= FELE_CG_IDLE;
            bit_cnt_ff   <= 3'h0;
            nib_cnt_ff   <= 12'h000;
            frame_err_ff <= 1'b0;
            scr_ff       <= FELE_SCR_SEED;
            nrzi_ff      <= 1'b0;
            mlt3_ff      <= FELE_LVL_LOW;
            field_ff     <= FELE_FLD_IDLE;
        end
        else
        begin
            tx_state_ff  <= nxt_tx_state;
            mlt_state_ff <= nxt_mlt_state;
            shift_ff     <= nxt_shift;
            bit_cnt_ff   <= nxt_bit_cnt;
            nib_cnt_ff   <= nxt_nib_cnt;
            frame_err_ff <= nxt_frame_err;
            scr_ff       <= nxt_scr;
            nrzi_ff      <= nxt_nrzi;
            mlt3_ff      <= nxt_mlt3;
            field_ff     <= nxt_field;
        end
    end

    assign o_tx_nrzi      = nrzi_ff;
    assign o_tx_mlt3      = mlt3_ff;
    assign o_tx_field     = field_ff;
    assign o_tx_frame_err = frame_err_ff;

    fele_rx_decode u_rx_decode
    (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_code     (i_rx_code),
        .i_code_vld (i_rx_code_vld),
        .o_nibble   (o_rx_nibble),
        .o_data_vld (o_rx_data_vld),
        .o_ctrl     (o_rx_ctrl),
        .o_sym_err  (o_rx_sym_err)
    );

    a_nrzi_one_toggles: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        line_bit |=> (o_tx_nrzi != $past(o_tx_nrzi)))
        else $error("NRZI did not toggle on a one.");

    a_nrzi_zero_holds: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        !line_bit |=> $stable(o_tx_nrzi))
        else $error("NRZI changed on a zero.");

    a_mlt3_three_levels: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (o_tx_mlt3 != FELE_LVL_BAD) &&
        (!$past(i_mode_tx) -> (o_tx_mlt3 == FELE_LVL_MID)))
        else $error("Three-level output left its legal levels.");

    a_mlt3_single_step: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        ($past(i_mode_tx) && $past(i_mode_tx, 2))
            |-> ($changed(o_tx_nrzi)
                 ? (o_tx_mlt3 == $past(o_tx_mlt3) + 2'h1 ||
                    o_tx_mlt3 == $past(o_tx_mlt3) - 2'h1)
                 : $stable(o_tx_mlt3)))
        else $error("Three-level output moved wrongly.");

    a_mlt3_rise_path: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_mode_tx && mlt_state_ff == ML_LOW && line_bit)
            |=> (o_tx_mlt3 == FELE_LVL_MID))
        else $error("Low level did not step to middle.");

    a_mlt3_fall_path: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_mode_tx && mlt_state_ff == ML_HIGH && line_bit)
            |=> (o_tx_mlt3 == FELE_LVL_MID) ##0 (mlt_state_ff == ML_MID_DN))
        else $error("High level did not step down to middle.");

    a_scr_running: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (scr_ff != 11'h000) &&
        (!$past(i_rst_b) || (scr_ff != $past(scr_ff))))
        else $error("Scrambler stalled or locked at zero.");

    a_ssd_pair: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (load && tx_state_ff == TX_IDLE && i_tx_en)
            |=> (shift_ff == FELE_CG_SSD1) ##5 (shift_ff == FELE_CG_SSD2))
        else $error("Start delimiter pair not sent.");

    a_esd_pair: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (load && tx_state_ff == TX_DATA && !i_tx_en)
            |=> (shift_ff == FELE_CG_ESD1) ##5 (shift_ff == FELE_CG_ESD2)
            ##5 (shift_ff == FELE_CG_IDLE))
        else $error("End delimiter pair or idle not sent.");

    a_data_mapping: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (load && tx_state_ff == TX_DATA && i_tx_en && !i_tx_er)
            |=> (shift_ff == fele_enc4b5b($past(i_txd))))
        else $error("Data nibble mapped to wrong code group.");

    a_no_invalid_sent: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (bit_cnt_ff == 3'h0) |-> !fele_is_invalid(shift_ff))
        else $error("Invalid code group sent.");

    a_short_frame_err: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (load && tx_state_ff == TX_DATA && !i_tx_en &&
         nib_cnt_ff < FELE_NIB_MIN) |=> o_tx_frame_err)
        else $error("Short frame not flagged.");

endmodule // fele_line_coder

// File: core/fele_pkg.sv
// Purpose: Shared constants and code tables for the line encoder.
// Assumes: One coded bit per core clock; code groups go MSB first.
// Notes:   Level codes on the line output are low, middle and high.
package fele_pkg;

    // Code groups for control symbols.
    localparam logic [4:0] FELE_CG_IDLE  = 5'h1f;
    localparam logic [4:0] FELE_CG_SSD1  = 5'h18;
    localparam logic [4:0] FELE_CG_SSD2  = 5'h11;
    localparam logic [4:0] FELE_CG_ESD1  = 5'h0d;
    localparam logic [4:0] FELE_CG_ESD2  = 5'h07;
    localparam logic [4:0] FELE_CG_TXERR = 5'h04;

    // Serialiser: bit index on which the next group is loaded.
    localparam logic [2:0] FELE_BIT_LAST = 3'h4;

    // Frame field lengths in octets.
    localparam int FELE_OCT_PRE     = 8;
    localparam int FELE_OCT_DA      = 6;
    localparam int FELE_OCT_SA      = 6;
    localparam int FELE_OCT_LEN     = 2;
    localparam int FELE_OCT_PAY_MIN = 46;
    localparam int FELE_OCT_PAY_MAX = 1500;
    localparam int FELE_OCT_CRC     = 4;

    // Nibble counts at which each field ends, counted from the frame start, plus frame length limits and counter saturation.
    localparam logic [11:0] FELE_NIB_PRE_END = 12'(2 * FELE_OCT_PRE);
    localparam logic [11:0] FELE_NIB_DA_END  =
        12'(2 * (FELE_OCT_PRE + FELE_OCT_DA));
    localparam logic [11:0] FELE_NIB_SA_END  =
        12'(2 * (FELE_OCT_PRE + FELE_OCT_DA + FELE_OCT_SA));
    localparam logic [11:0] FELE_NIB_LEN_END =
        12'(2 * (FELE_OCT_PRE + FELE_OCT_DA + FELE_OCT_SA + FELE_OCT_LEN));
    localparam logic [11:0] FELE_NIB_MIN     =
        12'(2 * (FELE_OCT_PRE + FELE_OCT_DA + FELE_OCT_SA + FELE_OCT_LEN
                 + FELE_OCT_PAY_MIN + FELE_OCT_CRC));
    localparam logic [11:0] FELE_NIB_MAX     =
        12'(2 * (FELE_OCT_PRE + FELE_OCT_DA + FELE_OCT_SA + FELE_OCT_LEN
                 + FELE_OCT_PAY_MAX + FELE_OCT_CRC));
    localparam logic [11:0] FELE_NIB_SAT     = 12'hfff;

    // Field indication codes.
    localparam logic [2:0] FELE_FLD_IDLE = 3'h0;
    localparam logic [2:0] FELE_FLD_PRE  = 3'h1;
    localparam logic [2:0] FELE_FLD_DA   = 3'h2;
    localparam logic [2:0] FELE_FLD_SA   = 3'h3;
    localparam logic [2:0] FELE_FLD_LEN  = 3'h4;
    localparam logic [2:0] FELE_FLD_DATA = 3'h5;
    localparam logic [2:0] FELE_FLD_END  = 3'h6;

    // Three-level line codes.
    localparam logic [1:0] FELE_LVL_LOW  = 2'h0;
    localparam logic [1:0] FELE_LVL_MID  = 2'h1;
    localparam logic [1:0] FELE_LVL_HIGH = 2'h2;
    localparam logic [1:0] FELE_LVL_BAD  = 2'h3;

    // Receive control kinds.
    localparam logic [2:0] FELE_RXC_NONE  = 3'h0;
    localparam logic [2:0] FELE_RXC_IDLE  = 3'h1;
    localparam logic [2:0] FELE_RXC_SSD1  = 3'h2;
    localparam logic [2:0] FELE_RXC_SSD2  = 3'h3;
    localparam logic [2:0] FELE_RXC_ESD1  = 3'h4;
    localparam logic [2:0] FELE_RXC_ESD2  = 3'h5;
    localparam logic [2:0] FELE_RXC_TXERR = 3'h6;

    // Scrambler state after reset; any nonzero value works.
    localparam logic [10:0] FELE_SCR_SEED = 11'h7ff;

    function automatic logic [4:0] fele_enc4b5b(input logic [3:0] nib);
        logic [4:0] cg;
        cg = FELE_CG_IDLE;
        unique case (nib)
            4'h0: cg = 5'h1e;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0a;
            4'h5: cg = 5'h0b;
            4'h6: cg = 5'h0e;
            4'h7: cg = 5'h0f;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'ha: cg = 5'h16;
            4'hb: cg = 5'h17;
            4'hc: cg = 5'h1a;
            4'hd: cg = 5'h1b;
            4'he: cg = 5'h1c;
            4'hf: cg = 5'h1d;
        endcase
        return cg;
    endfunction

    // Returns {is_data, nibble}; is_data low for any non-data group.
    function automatic logic [4:0] fele_dec5b4b(input logic [4:0] cg);
        logic [4:0] res;
        res = 5'h00;
        for (int n = 0; n < 16; n++)
        begin
            if (fele_enc4b5b(4'(n)) == cg)
            begin
                res = {1'b1, 4'(n)};
            end
        end
        return res;
    endfunction

    function automatic logic fele_is_invalid(input logic [4:0] cg);
        return (cg == 5'h00) || (cg == 5'h01) || (cg == 5'h02) ||
               (cg == 5'h03) || (cg == 5'h05) || (cg == 5'h06) ||
               (cg == 5'h08) || (cg == 5'h0c) || (cg == 5'h10);
    endfunction

endpackage

// File: core/fele_rx_decode.sv
// Purpose: Receive code group decoder with symbol error flagging.
// Assumes: Groups arrive aligned and descrambled, one per valid strobe.
// Notes:   Outputs are registered; only the nibble stands until the next strobe, the rest clear.
`timescale 1ns/100ps
module fele_rx_decode
    import fele_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_b,
    // Aligned code groups.
    input  wire logic [4:0] i_code,
    input  wire logic       i_code_vld,
    // Decoded output.
    output logic      [3:0] o_nibble,
    output logic            o_data_vld,
    output logic      [2:0] o_ctrl,
    output logic            o_sym_err
);

    logic [3:0] nibble_ff;
    logic [3:0] nxt_nibble;
    logic       data_vld_ff;
    logic       nxt_data_vld;
    logic [2:0] ctrl_ff;
    logic [2:0] nxt_ctrl;
    logic       sym_err_ff;
    logic       nxt_sym_err;
    logic [4:0] dec;

    always_comb
    begin
        dec          = fele_dec5b4b(i_code);
        nxt_nibble   = nibble_ff;
        nxt_data_vld = 1'b0;
        nxt_ctrl     = FELE_RXC_NONE;
        nxt_sym_err  = 1'b0;
        if (i_code_vld)
        begin
            nxt_data_vld = dec[4];
            nxt_nibble   = dec[4] ? dec[3:0] : 4'h0;
            nxt_sym_err  = fele_is_invalid(i_code);
            unique case (i_code)
                FELE_CG_IDLE:  nxt_ctrl = FELE_RXC_IDLE;
                FELE_CG_SSD1:  nxt_ctrl = FELE_RXC_SSD1;
                FELE_CG_SSD2:  nxt_ctrl = FELE_RXC_SSD2;
                FELE_CG_ESD1:  nxt_ctrl = FELE_RXC_ESD1;
                FELE_CG_ESD2:  nxt_ctrl = FELE_RXC_ESD2;
                FELE_CG_TXERR: nxt_ctrl = FELE_RXC_TXERR;
                default:       nxt_ctrl = FELE_RXC_NONE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            nibble_ff   <= 4'h0;
            data_vld_ff <= 1'b0;
            ctrl_ff     <= FELE_RXC_NONE;
            sym_err_ff  <= 1'b0;
        end
        else
        begin
            nibble_ff   <= nxt_nibble;
            data_vld_ff <= nxt_data_vld;
            ctrl_ff     <= nxt_ctrl;
            sym_err_ff  <= nxt_sym_err;
        end
    end

    assign o_nibble   = nibble_ff;
    assign o_data_vld = data_vld_ff;
    assign o_ctrl     = ctrl_ff;
    assign o_sym_err  = sym_err_ff;

    a_invalid_flagged: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_code_vld && fele_is_invalid(i_code))
            |=> (o_sym_err && !o_data_vld))
        else $error("Invalid code group not flagged as symbol error.");

endmodule // fele_rx_decode

// File: test/fele_line_model.sv
// Purpose: Line side model that recovers bits and tracks levels.
// Assumes: Line outputs settle between rising edges.
// Notes:   Counts every level that breaks the three-level cycle.
`timescale 1ns/100ps
module fele_line_model
    import fele_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    // Line inputs.
    input  wire logic        i_mode_tx,
    input  wire logic        i_nrzi,
    input  wire logic  [1:0] i_level,
    // Recovered stream and error count.
    output logic             o_bit,
    output logic      [15:0] o_bad_steps
);
    logic       last_ff;
    logic       up_ff;
    logic       mode_ff;
    logic [1:0] lvl_ff;
    logic [1:0] nl;
    logic       nu;

    assign o_bit = i_nrzi ^ last_ff;

    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            last_ff <= 1'b0;
            up_ff <= 1'b1;
            mode_ff <= 1'b1;
            lvl_ff <= FELE_LVL_LOW;
            o_bad_steps <= 16'h0000;
        end
        else
        begin
            nl = lvl_ff;
            nu = up_ff;
            if (mode_ff && (i_nrzi ^ last_ff))
            begin
                if (lvl_ff == FELE_LVL_HIGH) nu = 1'b0;
                if (lvl_ff == FELE_LVL_LOW) nu = 1'b1;
                nl = nu ? lvl_ff + 2'h1 : lvl_ff - 2'h1;
            end
            if (i_level !== (mode_ff ? nl : FELE_LVL_MID))
                o_bad_steps <= o_bad_steps + 16'h0001;
            lvl_ff <= nl;
            up_ff <= nu;
            last_ff <= i_nrzi;
            mode_ff <= i_mode_tx;
        end
    end
endmodule // fele_line_model

// File: test/tb_top.sv
// Purpose: Self-checking bench for the line encoder.
// Assumes: Stimulus moves on rising edges by non-blocking assignment.
// Notes:   Fiber mode is used to read code groups off the line unscrambled.
`timescale 1ns/100ps
module tb_top
    import fele_pkg::*;
;
    logic        i_core_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_mode_tx = 1'b1;
    logic        i_tx_en = 1'b0;
    logic        i_tx_er = 1'b0;
    logic  [3:0] i_txd = 4'h0;
    logic  [4:0] i_rx_code = 5'h00;
    logic        i_rx_code_vld = 1'b0;
    logic        o_tx_take, o_tx_frame_err, o_tx_nrzi, line_bit;
    logic  [2:0] o_tx_field, o_rx_ctrl;
    logic  [1:0] o_tx_mlt3;
    logic  [3:0] o_rx_nibble;
    logic        o_rx_data_vld, o_rx_sym_err;
    logic [15:0] bad_steps;
    int          err_total = 0;
    int          n_checks = 0;
    int          fcnt[8];
    int          ferr = 0;
    logic        collect = 1'b0;
    logic        q[$];
    logic  [4:0] enc[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
        5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    always #25 i_core_clk = ~i_core_clk;

    fele_line_coder fele_line_coder_inst (.i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b), .i_mode_tx(i_mode_tx), .i_tx_en(i_tx_en),
        .i_tx_er(i_tx_er), .i_txd(i_txd), .o_tx_take(o_tx_take),
        .o_tx_field(o_tx_field), .o_tx_frame_err(o_tx_frame_err),
        .o_tx_nrzi(o_tx_nrzi), .o_tx_mlt3(o_tx_mlt3),
        .i_rx_code(i_rx_code), .i_rx_code_vld(i_rx_code_vld),
        .o_rx_nibble(o_rx_nibble), .o_rx_data_vld(o_rx_data_vld),
        .o_rx_ctrl(o_rx_ctrl), .o_rx_sym_err(o_rx_sym_err));

    fele_line_model fele_line_model_inst (.i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b), .i_mode_tx(i_mode_tx), .i_nrzi(o_tx_nrzi),
        .i_level(o_tx_mlt3), .o_bit(line_bit), .o_bad_steps(bad_steps));

    always @(posedge i_core_clk)
    begin
        if (i_rst_b)
        begin
            fcnt[o_tx_field] += 1;
            ferr += o_tx_frame_err;
            if (collect) q.push_back(line_bit);
        end
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Sends n nibbles; nibble er_at carries the transmit error flag.
    task automatic send_frame(input int n, input int er_at);
        int k;
        int t;
        k = 0;
        t = 0;
        fcnt = '{default: 0};
        ferr = 0;
        i_tx_en <= 1'b1;
        i_txd <= 4'h3;
        while (k < n && t < 20000)
        begin
            @(posedge i_core_clk);
            t++;
            if (o_tx_take === 1'b1)
            begin
                k++;
                i_txd <= 4'(k * 7 + 3);
                i_tx_er <= (k == er_at);
                i_tx_en <= (k < n);
            end
        end
        chk("frame takes", n, k);
        repeat (25) @(posedge i_core_clk);
    endtask

    task automatic t_rx_table();
        logic [4:0] c;
        logic [3:0] nb;
        logic [2:0] ct;
        logic       dv;
        for (int v = 0; v < 32; v++)
        begin
            c = 5'(v);
            nb = 4'h0;
            dv = 1'b0;
            for (int d = 0; d < 16; d++)
                if (enc[d] == c)
                begin
                    nb = 4'(d);
                    dv = 1'b1;
                end
            case (c)
                5'h1f: ct = FELE_RXC_IDLE;
                5'h18: ct = FELE_RXC_SSD1;
                5'h11: ct = FELE_RXC_SSD2;
                5'h0d: ct = FELE_RXC_ESD1;
                5'h07: ct = FELE_RXC_ESD2;
                5'h04: ct = FELE_RXC_TXERR;
                default: ct = FELE_RXC_NONE;
            endcase
            @(posedge i_core_clk);
            i_rx_code <= c;
            i_rx_code_vld <= 1'b1;
            @(posedge i_core_clk);
            i_rx_code_vld <= 1'b0;
            #1;
            if (c != 5'h19)
            begin
                chk("rx nibble", nb, o_rx_nibble);
                chk("rx data", dv, o_rx_data_vld);
                chk("rx ctrl", ct, o_rx_ctrl);
                chk("rx sym err", v inside {0, 1, 2, 3, 5, 6, 8, 12, 16},
                    o_rx_sym_err);
            end
        end
        $display("test rx_table done");
    endtask

    task automatic t_frames();
        int n[4] = '{144, 142, 3052, 3054};
        for (int i = 0; i < 4; i++)
        begin
            send_frame(n[i], -1);
            chk("frame err", i % 2, ferr);
            if (i % 2 == 0)
            begin
                chk("pre cycles", 80, fcnt[1]);
                chk("da cycles", 60, fcnt[2]);
                chk("sa cycles", 60, fcnt[3]);
                chk("len cycles", 20, fcnt[4]);
                chk("data cycles", 5 * (n[i] - FELE_NIB_LEN_END),
                    fcnt[5]);
                chk("end cycles", 10, fcnt[6]);
            end
        end
        chk("bad levels", 0, bad_steps);
        $display("test frames done");
    endtask

    task automatic t_scramble();
        int z;
        z = 0;
        q.delete();
        collect = 1'b1;
        repeat (60) @(posedge i_core_clk);
        collect = 1'b0;
        foreach (q[i]) z += (q[i] == 1'b0);
        chk("idle zeros", 1, z > 0);
        $display("test scramble done");
    endtask

    task automatic t_fiber();
        int s;
        logic [4:0] g;
        logic [4:0] e;
        s = -1;
        i_mode_tx <= 1'b0;
        repeat (10) @(posedge i_core_clk);
        q.delete();
        collect = 1'b1;
        send_frame(144, 30);
        collect = 1'b0;
        for (int i = 0; i + 10 <= q.size() && s < 0; i++)
            if ({q[i], q[i+1], q[i+2], q[i+3], q[i+4], q[i+5], q[i+6],
                 q[i+7], q[i+8], q[i+9]} == {FELE_CG_SSD1, FELE_CG_SSD2})
                s = i;
        chk("start found", 1, s >= 0);
        for (int j = 0; j < 147 && s >= 0 && s + 5 * j + 5 <= q.size(); j++)
        begin
            g = {q[s+5*j], q[s+5*j+1], q[s+5*j+2], q[s+5*j+3], q[s+5*j+4]};
            e = (j == 0) ? FELE_CG_SSD1 : (j == 1) ? FELE_CG_SSD2 :
                (j == 30) ? FELE_CG_TXERR : (j == 144) ? FELE_CG_ESD1 :
                (j == 145) ? FELE_CG_ESD2 : (j == 146) ? FELE_CG_IDLE :
                enc[4'(j * 7 + 3)];
            if (j < 2 || j > 143 || j == 30)
                chk("ctl group", e, g);
            else
                chk("data group", e, g);
        end
        chk("bad levels", 0, bad_steps);
        $display("test fiber done");
    endtask

    initial
    begin
        repeat (2) @(posedge i_core_clk);
        chk("reset level", FELE_LVL_LOW, o_tx_mlt3);
        chk("reset field", FELE_FLD_IDLE, o_tx_field);
        @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        $display("test reset done");
        t_scramble();
        t_rx_table();
        t_frames();
        t_fiber();
        wrap_up();
    end

    initial
    begin
        #3000000;
        err_total++;
        wrap_up();
    end
endmodule // tb_top
